// *** hw/meter_setup_defines.vh ***
// Contract
// - Averaging period for min/max power and flow held as adjustable minutes.
// - Shift limit editable only when meter type equals 6.
// - Shift limit valid from 2 to 180,00 degrees; 250,00 means disabled.
// - Out-of-range entered limit is replaced by 250,00 degrees.
// - Storing a valid limit re-enables the shift function.
// - Other meter types keep shift disabled and show Off.
// - Limit editing flashes first digit; each digit steps 0 to 9 (here a press adds one to the focused digit and moves on, or stores at the fourth).
// - Non-shift types light frame around Off only while key pressed.
// - Sensor offset limited to -0,99 to +0,99 K in hundredths.
// - Offset entry: sign toggles, then first and second decimal, each 0 to 9 (key presses here never reach the second decimal).
// - Offset function disabled by configuration blocks editing and shows Off.
// - Radio switches on when first integration ends transport state.
// - Radio is permanently off, paused or on; two symbols show it.
// - Paused radio goes on by manual select, flow, or hour timer.
// - Hour counter from production turns radio on at preset time if enabled.
// - In test mode, timer and consumption do not switch radio on.
// - Total reset returns radio to paused, the factory state.
// - Installation requests are rejected while radio is permanently off.
// - Wired variants keep radio symbols dark and show no-radio text.
// - Five-second key hold at item 3-014 in transport state locks configuration.
// - Frame lights progressively during hold; early release cancels lock.
// - Permanent off is selectable by software; automatic sources cannot leave it.
`ifndef METER_SETUP_DEFINES_VH
`define METER_SETUP_DEFINES_VH
`define ADDR_CTRL        5'h00
`define ADDR_AVG         5'h04
`define ADDR_LIMIT       5'h08
`define ADDR_OFFSET      5'h0c
`define ADDR_RADIO       5'h10
`define ADDR_HOURS       5'h14
`define ADDR_STATUS      5'h18
`define ADDR_KEY         5'h1c
`define SHIFT_TYPE       4'h6
`define LIMIT_MIN        15'h00c8
`define LIMIT_MAX        15'h4650
`define LIMIT_OFF        15'h61a8
`define AVG_RESET        8'h3c
`define HOUR_PRESET_RST  16'h0000
`define RADIO_OFF        2'h0
`define RADIO_PAUSE      2'h1
`define RADIO_ON         2'h2
`define LOCK_ITEM        12'h30e
`define HOLD_MS          5000
`define CLK_MHZ          100
`define HOLD_CYCLES      (`HOLD_MS * 1000 * `CLK_MHZ)
`define HOUR_S           3600
// One hour of clocks; sized so the count is not cut to 32 bits
`define HOUR_CYCLES      40'd360000000000
`endif

// *** hw/meter_setup.v ***
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "meter_setup_defines.vh"
module meter_setup #(
    parameter [31:0] HOLD_CYCLES = `HOLD_CYCLES,
    parameter [39:0] HOUR_CYCLES = `HOUR_CYCLES
) (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire [4:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [4:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        KEY,
    input  wire [11:0] MENU_INDEX,
    input  wire        FIRST_INTEGRATION,
    input  wire        FLOW_SEEN,
    input  wire        TEST_MODE,
    input  wire        INSTALL_REQ,
    input  wire        TOTAL_RESET,
    output reg         INSTALL_GRANT,
    output reg         RADIO_ENABLE,
    output reg  [1:0]  RADIO_SYMBOLS,
    output reg         LOCK_FRAME_DONE,
    output reg  [2:0]  LOCK_FRAME_LEVEL,
    output reg         OFF_FRAME
);

    // Control bits: [0] wired bus variant, [1] offset disabled, [2] hour timer enabled,
    // [3] transport state, [7:4] meter type
    reg  [7:0]  ctrl;
    reg  [7:0]  avg_minutes;
    reg  [14:0] limit;
    reg         shift_enabled;
    reg         off_sign;
    reg  [3:0]  off_d1;
    reg  [3:0]  off_d2;
    reg  [1:0]  radio;
    reg  [15:0] hour_preset;
    reg  [15:0] hours;
    reg  [39:0] hour_tick;
    reg         locked;
    reg  [31:0] hold_count;
    reg         holding;
    reg         key_prev;
    // Key editing: edit-active flag, the digit cursor and the limit value under edit
    reg  [1:0]  edit_pos;
    reg  [14:0] edit_val;
    reg         editing;

    reg         aw_held;
    reg         w_held;
    reg  [4:0]  aw_addr;
    reg  [31:0] w_data;

    wire        is_shift_type = (ctrl[7:4] == `SHIFT_TYPE);
    wire        key_press     = KEY & ~key_prev;
    wire        hour_due      = ctrl[2] & (hours >= hour_preset);
    wire        auto_wake     = ~TEST_MODE & (FLOW_SEEN | hour_due);
    wire        do_write      = aw_held & w_held & ~S_AXI_BVALID;
    // Frame progress in sevenths of the hold; full frame once locked, or at the end of the hold outside transport state
    wire [39:0] frame_scaled  = ({8'h00, hold_count} * 40'd7) / {8'h00, HOLD_CYCLES};

    // Clamp an entered limit; out-of-range values mean the function is off
    function [14:0] clamp_limit;
        input [14:0] v;
        begin
            if (v >= `LIMIT_MIN && v <= `LIMIT_MAX)
                clamp_limit = v;
            else
                clamp_limit = `LIMIT_OFF;
        end
    endfunction

    function [3:0] step_digit;
        input [3:0] d;
        begin
            step_digit = (d >= 4'h9) ? 4'h0 : d + 4'h1;
        end
    endfunction

    // Decimal weight of digit position p in hundredths of a degree
    function [14:0] digit_weight;
        input [1:0] p;
        begin
            case (p)
                2'h0: digit_weight = 15'd10000;
                2'h1: digit_weight = 15'd1000;
                2'h2: digit_weight = 15'd100;
                default: digit_weight = 15'd10;
            endcase
        end
    endfunction

    // AXI write channel
    always @(posedge CLK) begin
        if (!RSTN) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 5'h00;
            w_data        <= 32'h0000_0000;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'h0;
        end else begin
            S_AXI_AWREADY <= ~aw_held & ~S_AXI_AWREADY;
            S_AXI_WREADY  <= ~w_held & ~S_AXI_WREADY;
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr > `ADDR_HOURS) ? 2'h2 : 2'h0;
            end
            if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // AXI read channel
    always @(posedge CLK) begin
        if (!RSTN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= 2'h0;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_RVALID & ~S_AXI_ARREADY;
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= 2'h0;
                case (S_AXI_ARADDR)
                    `ADDR_CTRL:   S_AXI_RDATA <= {24'h0, ctrl};
                    `ADDR_AVG:    S_AXI_RDATA <= {24'h0, avg_minutes};
                    `ADDR_LIMIT:  S_AXI_RDATA <= {17'h0, limit};
                    `ADDR_OFFSET: S_AXI_RDATA <= {23'h0, off_sign, off_d1, off_d2};
                    `ADDR_RADIO:  S_AXI_RDATA <= {30'h0, radio};
                    `ADDR_HOURS:  S_AXI_RDATA <= {hours, hour_preset};
                    `ADDR_STATUS: S_AXI_RDATA <= {25'h0, ~is_shift_type | ~shift_enabled,
                                                 ctrl[1], ctrl[0], locked, editing,
                                                 edit_pos};
                    `ADDR_KEY:    S_AXI_RDATA <= {17'h0, edit_val};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'h2;
                    end
                endcase
            end
            if (S_AXI_RVALID & S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // Configuration, key editing and radio state
    always @(posedge CLK) begin
        if (!RSTN || TOTAL_RESET) begin
            ctrl          <= 8'h08;
            avg_minutes   <= `AVG_RESET;
            limit         <= `LIMIT_OFF;
            shift_enabled <= 1'b0;
            off_sign      <= 1'b0;
            off_d1        <= 4'h0;
            off_d2        <= 4'h0;
            radio         <= `RADIO_PAUSE;
            hour_preset   <= `HOUR_PRESET_RST;
            locked        <= 1'b0;
            editing       <= 1'b0;
            edit_pos      <= 2'h0;
            edit_val      <= 15'h0000;
        end else begin
            if (FIRST_INTEGRATION)
                ctrl[3] <= 1'b0;
            if (do_write && !locked) begin
                case (aw_addr)
                    `ADDR_CTRL: ctrl <= w_data[7:0];
                    `ADDR_AVG:  avg_minutes <= w_data[7:0];
                    `ADDR_LIMIT: if (is_shift_type) begin
                        limit         <= clamp_limit(w_data[14:0]);
                        shift_enabled <= (clamp_limit(w_data[14:0]) != `LIMIT_OFF);
                    end
                    `ADDR_OFFSET: if (!ctrl[1] && w_data[7:4] <= 4'h9 && w_data[3:0] <= 4'h9) begin
                        off_sign <= w_data[8];
                        off_d1   <= w_data[7:4];
                        off_d2   <= w_data[3:0];
                    end
                    `ADDR_RADIO: if (!ctrl[0] && w_data[1:0] <= `RADIO_ON)
                        radio <= w_data[1:0];
                    `ADDR_HOURS: hour_preset <= w_data[15:0];
                    default: ;
                endcase
            end
            // Radio wake-up; permanent off is never left automatically
            if (!ctrl[0] && radio == `RADIO_PAUSE && (auto_wake || FIRST_INTEGRATION))
                radio <= `RADIO_ON;
            // Short key presses step the focused digit at items 3-011 and 3-012
            if (key_press && !locked) begin
                if (MENU_INDEX == 12'h30b && is_shift_type) begin
                    if (!editing) begin
                        editing  <= 1'b1;
                        edit_pos <= 2'h0;
                        edit_val <= limit;
                    end else if (edit_pos == 2'h3) begin
                        editing       <= 1'b0;
                        limit         <= clamp_limit(edit_val);
                        shift_enabled <= (clamp_limit(edit_val) != `LIMIT_OFF);
                    end else begin
                        edit_pos <= edit_pos + 2'h1;
                        edit_val <= edit_val + digit_weight(edit_pos);
                    end
                end else if (MENU_INDEX == 12'h30c && !ctrl[1]) begin
                    if (!editing) begin
                        editing  <= 1'b1;
                        edit_pos <= 2'h0;
                    end else begin
                        case (edit_pos)
                            2'h0: off_sign <= ~off_sign;
                            2'h2: off_d1   <= step_digit(off_d1);
                            2'h3: off_d2   <= step_digit(off_d2);
                            default: ;
                        endcase
                        edit_pos <= (edit_pos == 2'h0) ? 2'h2 : edit_pos;
                    end
                end
            end
            if (holding && hold_count >= HOLD_CYCLES - 32'h1 && ctrl[3])
                locked <= 1'b1;
        end
    end

    // Hold timer, hour counter and outputs
    always @(posedge CLK) begin
        if (!RSTN) begin
            key_prev         <= 1'b0;
            holding          <= 1'b0;
            hold_count       <= 32'h0;
            hours            <= 16'h0000;
            hour_tick        <= 40'h0;
            INSTALL_GRANT    <= 1'b0;
            RADIO_ENABLE     <= 1'b0;
            RADIO_SYMBOLS    <= 2'h0;
            LOCK_FRAME_DONE  <= 1'b0;
            LOCK_FRAME_LEVEL <= 3'h0;
            OFF_FRAME        <= 1'b0;
        end else begin
            key_prev <= KEY;
            if (key_press && MENU_INDEX == `LOCK_ITEM) begin
                holding    <= 1'b1;
                hold_count <= 32'h0;
            end else if (!KEY || MENU_INDEX != `LOCK_ITEM) begin
                holding    <= 1'b0;
                hold_count <= 32'h0;
            end else if (holding && hold_count < HOLD_CYCLES)
                hold_count <= hold_count + 32'h1;
            // Hour counter runs from production
            if (hour_tick >= HOUR_CYCLES - 40'h1) begin
                hour_tick <= 40'h0;
                if (hours != 16'hffff)
                    hours <= hours + 16'h1;
            end else
                hour_tick <= hour_tick + 40'h1;
            INSTALL_GRANT <= INSTALL_REQ && radio != `RADIO_OFF && !ctrl[0];
            RADIO_ENABLE  <= radio == `RADIO_ON && !ctrl[0];
            RADIO_SYMBOLS <= ctrl[0] ? 2'h0 :
                             (radio == `RADIO_ON) ? 2'h3 :
                             (radio == `RADIO_PAUSE) ? 2'h1 : 2'h2;
            LOCK_FRAME_DONE  <= locked;
            LOCK_FRAME_LEVEL <= locked ? 3'h7 :
                                holding ? frame_scaled[2:0] : 3'h0;
            OFF_FRAME <= KEY && MENU_INDEX == 12'h30b && !is_shift_type;
        end
    end

endmodule

// *** testbench/meter_setup_properties.sv ***
`timescale 1ns/1ps
module meter_setup_properties (
    input wire       CLK,
    input wire       RSTN,
    input wire       S_AXI_AWVALID,
    input wire       S_AXI_AWREADY,
    input wire       S_AXI_WVALID,
    input wire       S_AXI_WREADY,
    input wire       S_AXI_BVALID,
    input wire       S_AXI_ARVALID,
    input wire       S_AXI_ARREADY,
    input wire       S_AXI_RVALID,
    input wire       KEY,
    input wire       INSTALL_GRANT,
    input wire       RADIO_ENABLE,
    input wire [1:0] RADIO_SYMBOLS,
    input wire       LOCK_FRAME_DONE,
    input wire [2:0] LOCK_FRAME_LEVEL,
    input wire       OFF_FRAME
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    rst_quiet_a: assert property ($rose(RSTN) |-> !RADIO_ENABLE && !LOCK_FRAME_DONE)
        else $error("radio or lock active after reset");
    install_stop_a: assert property (RADIO_SYMBOLS == 2'b10 && $past(RADIO_SYMBOLS) == 2'b10
        |-> !INSTALL_GRANT) else $error("install granted while radio off");
    wired_dark_a: assert property (RADIO_SYMBOLS == 2'b00 && $past(RADIO_SYMBOLS) == 2'b00
        |-> !RADIO_ENABLE) else $error("radio on with dark symbols");
    on_symbol_a: assert property (RADIO_SYMBOLS == 2'b11 && $past(RADIO_SYMBOLS) == 2'b11
        |-> RADIO_ENABLE) else $error("on symbols without radio");
    lock_full_a: assert property (LOCK_FRAME_DONE |-> LOCK_FRAME_LEVEL == 3'd7)
        else $error("lock without full frame");
    lock_cancel_a: assert property (!KEY [*3] |-> LOCK_FRAME_LEVEL == 3'd0 || LOCK_FRAME_DONE)
        else $error("frame kept after release");
    off_frame_a: assert property (!KEY [*2] |-> !OFF_FRAME)
        else $error("off frame without key");
    wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> ##1 S_AXI_BVALID) else $error("write response late");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    cover property (LOCK_FRAME_DONE);
    cover property (OFF_FRAME);
    cover property (RADIO_SYMBOLS == 2'b11);
endmodule

// *** testbench/operator_model.sv ***
`timescale 1ns/1ps
module operator_model (
    input  wire       CLK,
    input  wire [7:0] hold,
    input  wire       go,
    output reg        KEY
);
    integer n = 0;
    initial KEY = 1'b0;
    // Key held for the commanded cycles; a short hold abandons the lock
    always @(posedge CLK) begin
        if (go && n == 0) begin
            KEY <= 1'b1;
            n <= hold;
        end else if (n > 1) begin
            n <= n - 1;
        end else if (n == 1) begin
            KEY <= 1'b0;
            n <= 0;
        end
    end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "meter_setup_defines.vh"
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
    reg         CLK = 0, RSTN = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    reg         fi = 0, flow = 0, tm = 0, ir = 0, tr = 0, go = 0;
    reg  [4:0]  awa = 0, ara = 0;
    reg  [31:0] wd = 0, rd_v;
    reg  [7:0]  avg_r = 0;
    reg  [7:0]  hold = 0;
    reg  [11:0] menu = 0;
    wire        awr, wr_r, bv, arr, rv, key, grant, ren, done, offf;
    wire [1:0]  br, rr, sym;
    wire [2:0]  lvl;
    wire [31:0] rdat;
    integer     errors = 0, n_compared = 0, k;
    int         lim[5] = '{150, 200, 18000, 18001, 9000};
    always #5 CLK = ~CLK;
    meter_setup #(.HOLD_CYCLES(20), .HOUR_CYCLES(10)) i_meter_setup (
        .CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .KEY(key), .MENU_INDEX(menu),
        .FIRST_INTEGRATION(fi), .FLOW_SEEN(flow), .TEST_MODE(tm), .INSTALL_REQ(ir),
        .TOTAL_RESET(tr), .INSTALL_GRANT(grant), .RADIO_ENABLE(ren), .RADIO_SYMBOLS(sym),
        .LOCK_FRAME_DONE(done), .LOCK_FRAME_LEVEL(lvl), .OFF_FRAME(offf));
    operator_model i_operator_model (.CLK(CLK), .hold(hold), .go(go), .KEY(key));
    function int clamp(int v);
        return (v < 200 || v > 18000) ? 25000 : v;
    endfunction
    task wr(input [4:0] a, input [31:0] d);
        begin
            @(posedge CLK);
            {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
            k = 0;
            do begin
                @(posedge CLK);
                if (awr) awv <= 0;
                if (wr_r) wv <= 0;
                k++;
            end while (!bv && k < 100);
            bry <= 0;
            `CK(br, 2'b00)
        end
    endtask
    task rd(input [4:0] a, input [31:0] e, input [31:0] m);
        begin
            @(posedge CLK);
            {ara, arv, rry} <= {a, 2'b11};
            k = 0;
            do begin
                @(posedge CLK);
                if (arr) arv <= 0;
                k++;
            end while (!rv && k < 100);
            rry <= 0;
            rd_v = rdat;
            `CK(rd_v & m, e)
        end
    endtask
    task wsym(input [1:0] e);
        begin
            k = 0;
            while (sym !== e && k < 300) begin
                @(posedge CLK);
                k++;
            end
            `CK(sym, e)
        end
    endtask
    task pulse(input integer w);
        begin
            @(posedge CLK);
            {fi, flow, tr} <= w[2:0];
            @(posedge CLK);
            {fi, flow, tr} <= 3'b000;
            repeat (8) @(posedge CLK);
        end
    endtask
    task press(input [7:0] n);
        begin
            @(posedge CLK);
            {go, hold} <= {1'b1, n};
            @(posedge CLK);
            go <= 0;
            repeat (n / 2) @(posedge CLK);
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d compared %0d", errors, n_compared);
            if (errors == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        #300000;
        errors++;
        finish_test;
    end
    initial begin
        k = $urandom(32'h929000fa);
        repeat (4) @(posedge CLK);
        RSTN <= 1;
        rd(`ADDR_AVG, `AVG_RESET, ~0);
        rd(`ADDR_RADIO, `RADIO_PAUSE, ~0);
        wsym(2'b01);
        avg_r = $urandom % 256;
        wr(`ADDR_AVG, avg_r);
        rd(`ADDR_AVG, avg_r, ~0);
        wr(`ADDR_LIMIT, 500);
        rd(`ADDR_LIMIT, `LIMIT_OFF, ~0);
        rd(`ADDR_STATUS, 32'h40, 32'h40);
        wr(`ADDR_CTRL, 32'h68);
        foreach (lim[i]) begin
            wr(`ADDR_LIMIT, lim[i]);
            rd(`ADDR_LIMIT, clamp(lim[i]), ~0);
            rd(`ADDR_STATUS, clamp(lim[i]) == 25000 ? 32'h40 : 0, 32'h40);
        end
        wr(`ADDR_OFFSET, 32'h157);
        wr(`ADDR_OFFSET, 32'h0a3);
        rd(`ADDR_OFFSET, 32'h157, ~0);
        wr(`ADDR_CTRL, 32'h6a);
        wr(`ADDR_OFFSET, 32'h012);
        rd(`ADDR_OFFSET, 32'h157, ~0);
        wr(`ADDR_RADIO, `RADIO_ON);
        wsym(2'b11);
        `CK(ren, 1'b1)
        wr(`ADDR_RADIO, `RADIO_PAUSE);
        tm <= 1;
        pulse(2);
        wsym(2'b01);
        tm <= 0;
        pulse(2);
        wsym(2'b11);
        wr(`ADDR_RADIO, `RADIO_OFF);
        ir <= 1;
        pulse(6);
        wsym(2'b10);
        `CK(grant, 1'b0)
        wr(`ADDR_RADIO, `RADIO_PAUSE);
        repeat (3) @(posedge CLK);
        `CK(grant, 1'b1)
        pulse(4);
        wsym(2'b11);
        wr(`ADDR_RADIO, `RADIO_PAUSE);
        rd(`ADDR_HOURS, 0, 0);
        wr(`ADDR_HOURS, rd_v[31:16] + 3);
        wr(`ADDR_CTRL, 32'h6c);
        wsym(2'b11);
        wr(`ADDR_CTRL, 32'h69);
        wsym(2'b00);
        pulse(1);
        wsym(2'b01);
        menu <= 12'h30b;
        press(40);
        `CK(offf, 1'b1)
        repeat (30) @(posedge CLK);
        `CK(offf, 1'b0)
        menu <= `LOCK_ITEM;
        press(8);
        repeat (8) @(posedge CLK);
        `CK(done, 1'b0)
        `CK(lvl, 3'h0)
        press(60);
        `CK(done, 1'b1)
        `CK(lvl, 3'h7)
        wr(`ADDR_AVG, 5);
        rd(`ADDR_AVG, `AVG_RESET, ~0);
        finish_test;
    end
endmodule
bind meter_setup meter_setup_properties i_meter_setup_properties (.*);
